// ### iopu_periph.sv
// Memory and peripheral model on the far side of the unit's bus
`timescale 1ns/1ps
`default_nettype none
module iopu_periph (
    // Bus from the unit
    input wire logic        core_clk, mem_rd, mem_wr, io_rd, io_wr,
    input wire logic [15:0] addr,
    input wire logic [7:0]  data_out,
    // Wait states to insert
    input wire logic [3:0]  wait_cyc,
    output logic            bus_ready,
    output logic [7:0]      data_in
);
    logic [7:0]  mem [0:65535];
    logic [23:0] wlog [0:511];
    logic [7:0]  last = 8'h00;
    logic [3:0]  cnt = 4'h0;
    int          wn = 0;
    int          rn = 0;
    wire logic   strobe;

    assign strobe = mem_rd || mem_wr || io_rd || io_wr;
    assign bus_ready = strobe && (cnt >= wait_cyc);
    // Idle data line flips the last byte so a stale value never looks valid
    assign data_in = io_rd ? 8'h50 + rn[7:0] : mem_rd ? mem[addr] : ~last;
    always @(posedge core_clk) begin
        cnt <= (bus_ready || !strobe) ? 4'h0 : cnt + 4'h1;
        if (bus_ready && io_rd)
            rn <= rn + 1;
        if (bus_ready && mem_wr)
            mem[addr] <= data_out;
        if (bus_ready && io_wr) begin
            wlog[wn[8:0]] <= {addr, data_out};
            wn <= wn + 1;
        end
        if (bus_ready && (io_rd || mem_rd))
            last <= data_in;
    end
endmodule : iopu_periph
`default_nettype wire

// ### iopu_pkg.sv
// Package of constants for the I/O port instruction unit
package iopu_pkg;
    localparam logic [7:0] OPC_OUT_IMM   = 8'hD3;
    localparam logic [7:0] OPC_PREFIX_ED = 8'hED;
    localparam logic [7:0] OPC_OUT_INC   = 8'hA3;
    localparam logic [7:0] OPC_OUT_INC_R = 8'hB3;
    localparam logic [7:0] OPC_IN_DEC_R  = 8'hBA;
    localparam logic [1:0] OUT_REG_HI    = 2'h1;
    localparam logic [2:0] OUT_REG_LO    = 3'h1;
    localparam logic [2:0] SEL_B         = 3'h0;
    localparam logic [2:0] SEL_C         = 3'h1;
    localparam logic [2:0] SEL_D         = 3'h2;
    localparam logic [2:0] SEL_E         = 3'h3;
    localparam logic [2:0] SEL_H         = 3'h4;
    localparam logic [2:0] SEL_L         = 3'h5;
    localparam logic [2:0] SEL_A         = 3'h7;
    localparam logic [15:0] PC_REWIND    = 16'h0002;
    localparam logic [1:0] REFRESH_CYC   = 2'h2;
    localparam int FLAG_C = 0;
    localparam int FLAG_N = 1;
    localparam int FLAG_Z = 6;

    typedef enum logic [6:0] {
        IOPU_IDLE    = 7'h01,
        IOPU_MEM_RD  = 7'h02,
        IOPU_IO_RD   = 7'h04,
        IOPU_MEM_WR  = 7'h08,
        IOPU_IO_WR   = 7'h10,
        IOPU_REFRESH = 7'h20,
        IOPU_DONE    = 7'h40
    } iopu_state_t;
endpackage : iopu_pkg

// ### iopu_skid.sv
// Two-entry buffer between the unit and the bus drive stage
`timescale 1ns/1ps
`default_nettype none
module iopu_skid #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem [2];
    logic             rd_ptr, wr_ptr;
    logic [1:0]       count;
    logic             next_rd_ptr, next_wr_ptr;
    logic [1:0]       next_count;
    logic             push, pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
        // Storage needs no reset; a slot is only read once valid
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : iopu_skid
`default_nettype wire

// ### iopu_unit.sv
// Execution unit for I/O port transfer instructions
// Behaviour
// RULE_01 - Block input: C low, B high, store at pointer
// RULE_02 - Decrement pointer and count; rewind by two
// RULE_03 - Two refresh cycles after each byte
// RULE_04 - Zero count means 256 bytes
// RULE_05 - Block input end: set Z, N; keep C
// RULE_06 - D3 n: port n low, A high, write A
// RULE_07 - ED 01rrr001: C low, B high, register out
// RULE_08 - Source field selects B C D E H L A
// RULE_09 - ED A3: read memory, decrement count, address
// RULE_10 - Then increment pointer by one
// RULE_11 - Z from decremented count, set N, keep C
// RULE_12 - Repeat form rewinds while count nonzero
// RULE_13 - Port cycles flagged distinct from memory cycles
`timescale 1ns/1ps
`default_nettype none
module iopu_unit
    import iopu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Instruction issue
    input  wire logic        start,
    input  wire logic        ed_prefix,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  port_imm,
    output logic             busy,
    output logic             done,
    // Register file in
    input  wire logic [7:0]  reg_a,
    input  wire logic [7:0]  reg_b,
    input  wire logic [7:0]  reg_c,
    input  wire logic [7:0]  reg_d,
    input  wire logic [7:0]  reg_e,
    input  wire logic [15:0] memory_pointer_pair_in,
    input  wire logic [15:0] program_counter_in,
    input  wire logic [7:0]  flags_in,
    // Register results
    output logic [7:0]       count_out,
    output logic [15:0]      memory_pointer_pair,
    output logic [15:0]      program_counter,
    output logic [7:0]       flags_out,
    output logic             regs_wr,
    // Bus
    output logic [15:0]      addr,
    output logic [7:0]       data_out,
    input  wire logic [7:0]  data_in,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             io_rd,
    output logic             io_wr,
    output logic             refresh,
    input  wire logic        bus_ready,
    output logic             bad_opcode,
    // Interrupt window between iterations
    output logic             int_window
);
    iopu_state_t state, next_state;
    logic [7:0]  kind, next_kind;
    logic [7:0]  cnt, next_cnt;
    logic [15:0] ptr, next_ptr;
    logic [15:0] pc, next_pc;
    logic [15:0] port, next_port;
    logic [7:0]  tmp, next_tmp;
    logic [7:0]  flg, next_flg;
    logic [1:0]  ref_cnt, next_ref_cnt;
    logic        next_done, next_bad;
    logic        buf_in_valid, buf_in_ready, buf_out_valid;
    logic [7:0]  buf_out_data;
    logic [7:0]  src_byte;
    logic        is_out_reg;

    // Source register for ED 01rrr001; code 110 is unsupported
    always_comb begin
        case (opcode[5:3]) // RULE_08
            SEL_B:   src_byte = reg_b;
            SEL_C:   src_byte = reg_c;
            SEL_D:   src_byte = reg_d;
            SEL_E:   src_byte = reg_e;
            SEL_H:   src_byte = memory_pointer_pair_in[15:8];
            SEL_L:   src_byte = memory_pointer_pair_in[7:0];
            SEL_A:   src_byte = reg_a;
            default: src_byte = 8'h00;
        endcase
    end

    assign is_out_reg = ed_prefix && opcode[7:6] == OUT_REG_HI && opcode[2:0] == OUT_REG_LO
                        && opcode[5:3] != 3'h6; // RULE_07 RULE_08

    // Output bytes go through the buffer so a stalled port loses nothing
    iopu_skid #(.WIDTH(8)) u_skid (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (next_tmp),
        .out_valid (buf_out_valid),
        .out_ready (bus_ready && state == IOPU_IO_WR),
        .out_data  (buf_out_data)
    );

    assign busy       = (state != IOPU_IDLE);
    assign addr       = (state == IOPU_MEM_RD || state == IOPU_MEM_WR) ? ptr : port;
    assign data_out   = (state == IOPU_MEM_WR) ? tmp : buf_out_data;
    assign mem_rd     = (state == IOPU_MEM_RD);
    assign mem_wr     = (state == IOPU_MEM_WR);
    assign io_rd      = (state == IOPU_IO_RD); // RULE_13
    assign io_wr      = (state == IOPU_IO_WR) && buf_out_valid; // RULE_13
    assign refresh    = (state == IOPU_REFRESH);
    assign int_window = (state == IOPU_REFRESH); // RULE_03
    // Push the byte on the edge that enters the port write; tmp is still stale there
    assign buf_in_valid = (next_state == IOPU_IO_WR) && (state != IOPU_IO_WR);
    assign count_out  = cnt;
    assign memory_pointer_pair = ptr;
    assign program_counter = pc;
    assign flags_out  = flg;
    assign regs_wr    = done;

    always_comb begin
        next_state   = state;
        next_kind    = kind;
        next_cnt     = cnt;
        next_ptr     = ptr;
        next_pc      = pc;
        next_port    = port;
        next_tmp     = tmp;
        next_flg     = flg;
        next_ref_cnt = ref_cnt;
        next_done    = 1'b0;
        next_bad     = 1'b0;
        case (state)
            IOPU_IDLE: begin
                if (start) begin
                    next_kind = opcode;
                    next_cnt  = reg_b;
                    next_ptr  = memory_pointer_pair_in;
                    next_pc   = program_counter_in;
                    next_flg  = flags_in;
                    if (!ed_prefix && opcode == OPC_OUT_IMM) begin
                        next_port  = {reg_a, port_imm}; // RULE_06
                        next_tmp   = reg_a;
                        next_state = IOPU_IO_WR;
                    end else if (is_out_reg) begin
                        next_port  = {reg_b, reg_c}; // RULE_07
                        next_tmp   = src_byte;
                        next_state = IOPU_IO_WR;
                    end else if (ed_prefix && opcode == OPC_IN_DEC_R) begin
                        next_port  = {reg_b, reg_c}; // RULE_01
                        next_state = IOPU_IO_RD;
                    end else if (ed_prefix && (opcode == OPC_OUT_INC || opcode == OPC_OUT_INC_R)) begin
                        next_port  = {reg_b, reg_c}; // RULE_09
                        next_state = IOPU_MEM_RD; // RULE_09
                    end else begin
                        next_bad = 1'b1;
                    end
                end
            end
            IOPU_IO_RD: begin
                if (bus_ready) begin
                    next_tmp   = data_in; // RULE_01
                    next_state = IOPU_MEM_WR;
                end
            end
            IOPU_MEM_WR: begin
                if (bus_ready) begin
                    // Zero wraps to FF, so a zero start count gives 256 passes
                    next_cnt   = cnt - 8'h01; // RULE_02 RULE_04
                    next_ptr   = ptr - 16'h0001; // RULE_02
                    next_flg[FLAG_Z] = (cnt == 8'h01); // RULE_05
                    next_flg[FLAG_N] = 1'b1; // RULE_05
                    next_ref_cnt = REFRESH_CYC;
                    next_state = IOPU_REFRESH; // RULE_03
                end
            end
            IOPU_MEM_RD: begin
                if (bus_ready) begin
                    next_tmp   = data_in; // RULE_09
                    next_cnt   = cnt - 8'h01; // RULE_09 RULE_04
                    next_port  = {cnt - 8'h01, port[7:0]}; // RULE_09
                    next_flg[FLAG_Z] = (cnt == 8'h01); // RULE_11
                    next_flg[FLAG_N] = 1'b1; // RULE_11
                    next_state = IOPU_IO_WR;
                end
            end
            IOPU_IO_WR: begin
                if (bus_ready && buf_out_valid) begin
                    if (kind == OPC_OUT_INC || kind == OPC_OUT_INC_R) begin
                        next_ptr     = ptr + 16'h0001; // RULE_10
                        next_ref_cnt = REFRESH_CYC;
                        next_state   = IOPU_REFRESH; // RULE_03
                    end else begin
                        next_state = IOPU_DONE;
                    end
                end
            end
            IOPU_REFRESH: begin
                next_ref_cnt = ref_cnt - 2'h1;
                if (ref_cnt == 2'h1) begin
                    next_state = IOPU_DONE;
                    if ((kind == OPC_IN_DEC_R || kind == OPC_OUT_INC_R) && cnt != 8'h00) begin
                        next_pc = pc - PC_REWIND; // RULE_02 RULE_12
                    end
                end
            end
            IOPU_DONE: begin
                next_done  = 1'b1;
                next_state = IOPU_IDLE;
            end
            default: next_state = IOPU_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state      <= IOPU_IDLE;
            kind       <= 8'h00;
            cnt        <= 8'h00;
            ptr        <= 16'h0000;
            pc         <= 16'h0000;
            port       <= 16'h0000;
            tmp        <= 8'h00;
            flg        <= 8'h00;
            ref_cnt    <= 2'h0;
            done       <= 1'b0;
            bad_opcode <= 1'b0;
        end else begin
            state      <= next_state;
            kind       <= next_kind;
            cnt        <= next_cnt;
            ptr        <= next_ptr;
            pc         <= next_pc;
            port       <= next_port;
            tmp        <= next_tmp;
            flg        <= next_flg;
            ref_cnt    <= next_ref_cnt;
            done       <= next_done;
            bad_opcode <= next_bad;
        end
    end
endmodule : iopu_unit
`default_nettype wire

// ### iopu_unit_bench.sv
// Self-checking bench for the I/O port instruction unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module iopu_unit_bench
    import iopu_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        start = 1'b0;
    logic        ed_prefix = 1'b0;
    logic [7:0]  opcode = 8'h00, port_imm = 8'h00, reg_a = 8'h23, reg_b = 8'h10;
    logic [7:0]  reg_c = 8'h07, reg_d = 8'h5A, reg_e = 8'h3C, flags_in = 8'h01;
    logic [15:0] memory_pointer_pair_in = 16'h1234;
    logic [15:0] program_counter_in = 16'h0200;
    logic [3:0]  wait_cyc = 4'h0;
    logic        busy, done, regs_wr, mem_rd, mem_wr, io_rd, io_wr, refresh, bad_opcode, int_window, bus_ready;
    logic [7:0]  count_out, flags_out, data_out, data_in;
    logic [15:0] memory_pointer_pair, program_counter, addr;
    logic [7:0]  sel [8] = '{8'h10, 8'h07, 8'h5A, 8'h3C, 8'h12, 8'h34, 8'h00, 8'h23};
    int          bad_count = 0;
    int          total_checks = 0;

    iopu_unit uut (.*);
    iopu_periph u_per (.*);

    always #25 core_clk = ~core_clk;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    function automatic logic [2:0] zf();
        return {flags_out[FLAG_Z], flags_out[FLAG_N], flags_out[FLAG_C]};
    endfunction : zf

    // Issue one pass and wait for its end, sampling away from the clock edge
    task automatic run(input logic ed, input logic [7:0] op, input logic [7:0] imm);
        int n;
        @(posedge core_clk);
        start <= 1'b1;
        ed_prefix <= ed;
        opcode <= op;
        port_imm <= imm;
        @(posedge core_clk);
        start <= 1'b0;
        for (n = 0; n < 300; n++) begin
            @(negedge core_clk);
            if ((done | bad_opcode) === 1'b1)
                break;
        end
        if (n == 300) begin
            bad_count++;
            give_verdict();
        end
        if (done === 1'b1)
            `CHK("regs_wr", 1'b1, regs_wr)
    endtask : run

    task automatic load(input logic [7:0] b, input logic [15:0] h, input logic [3:0] w);
        @(posedge core_clk);
        reg_b <= b;
        memory_pointer_pair_in <= h;
        wait_cyc <= w;
    endtask : load

    // Reissues a repeating form itself with the returned count and pointer until all passes have run
    task automatic block_run(input logic [7:0] op, input int passes);
        for (int p = 1; p <= passes; p++) begin
            run(1'b1, op, 8'h00);
            `CHK("pc", (p < passes) ? 16'h01FE : 16'h0200, program_counter)
            if (p < passes)
                load(count_out, memory_pointer_pair, wait_cyc);
        end
    endtask : block_run

    initial begin
        u_per.mem[16'h1234] = 8'h59;
        u_per.mem[16'h1000] = 8'h51;
        u_per.mem[16'h1001] = 8'hA9;
        u_per.mem[16'h1002] = 8'h03;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        run(1'b0, OPC_OUT_IMM, 8'h01);
        `CHK("imm write", 24'h230123, u_per.wlog[0])
        `CHK("imm flags", 8'h01, flags_out)
        for (int r = 0; r < 8; r++) begin
            run(1'b1, {OUT_REG_HI, r[2:0], OUT_REG_LO}, 8'h00);
            if (r == 6)
                `CHK("code 110", 1'b1, bad_opcode)
            else
                `CHK("reg write", {16'h1007, sel[r]}, u_per.wlog[u_per.wn - 1])
        end
        `CHK("io writes", 8, u_per.wn)
        load(8'h10, 16'h1234, 4'h2);
        run(1'b1, OPC_OUT_INC, 8'h00);
        `CHK("output_and_increment write", 24'h0F0759, u_per.wlog[u_per.wn - 1])
        `CHK("output_and_increment count", 8'h0F, count_out)
        `CHK("output_and_increment ptr", 16'h1235, memory_pointer_pair)
        `CHK("output_and_increment flags", 3'b011, zf())
        load(8'h01, 16'h1234, 4'h0);
        run(1'b1, OPC_OUT_INC, 8'h00);
        `CHK("output_and_increment last", 16'h0007, u_per.wlog[u_per.wn - 1][23:8])
        `CHK("output_and_increment zero", 3'b111, zf())
        load(8'h03, 16'h1000, 4'h3);
        block_run(OPC_OUT_INC_R, 3);
        `CHK("output_increment_repeat bytes", 72'h020751_0107A9_000703,
            {u_per.wlog[u_per.wn - 3], u_per.wlog[u_per.wn - 2], u_per.wlog[u_per.wn - 1]})
        `CHK("output_increment_repeat ptr", 16'h1003, memory_pointer_pair)
        load(8'h03, 16'h1000, 4'h0);
        block_run(OPC_IN_DEC_R, 3);
        `CHK("block_input_decrement_repeat mem", 24'h525150, {u_per.mem[16'h0FFE], u_per.mem[16'h0FFF], u_per.mem[16'h1000]})
        `CHK("block_input_decrement_repeat ptr", 16'h0FFD, memory_pointer_pair)
        `CHK("block_input_decrement_repeat flags", 3'b111, zf())
        load(8'h00, 16'h2000, 4'h1);
        block_run(OPC_IN_DEC_R, 256);
        `CHK("block_input_decrement_repeat reads", 259, u_per.rn)
        `CHK("block_input_decrement_repeat wrap ptr", 16'h1F00, memory_pointer_pair)
        give_verdict();
    end
endmodule : iopu_unit_bench
`default_nettype wire

// ### iopu_unit_properties.sv
// Assertion checker for the I/O port instruction unit
`timescale 1ns/1ps
`default_nettype none
module iopu_unit_properties
    import iopu_pkg::*;
(
    // Control and strobes
    input wire logic        core_clk, rstn, start, ed_prefix, busy, done, bus_ready,
    input wire logic        mem_rd, mem_wr, io_rd, io_wr, refresh, int_window,
    // Operands and results
    input wire logic [7:0]  opcode, port_imm, reg_a, reg_b, reg_c, flags_in, count_out, flags_out, data_out,
    input wire logic [15:0] memory_pointer_pair_in, program_counter_in, memory_pointer_pair, program_counter, addr
);
    logic        ed_q;
    logic [7:0]  op_q, b_q, c_q, f_q;
    logic [15:0] ptr_q, pc_q;

    // Operands as the unit took them at issue
    always_ff @(posedge core_clk) begin
        if (start && !busy) begin
            {ed_q, op_q, b_q, c_q, f_q, ptr_q, pc_q} <= {ed_prefix, opcode, reg_b, reg_c, flags_in,
                memory_pointer_pair_in, program_counter_in};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_two_refresh;
        refresh [*2] ##1 !refresh;
    endsequence
    property p_onehot; $onehot0({mem_rd, mem_wr, io_rd, io_wr, refresh}); endproperty
    a_onehot: assert property (p_onehot) else $error("bus cycle kinds overlap");
    property p_window; int_window == refresh; endproperty
    a_window: assert property (p_window) else $error("interrupt window off refresh");
    property p_refresh; $rose(refresh) |-> s_two_refresh; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh burst length wrong");
    property p_in_addr; io_rd |-> addr == {b_q, c_q}; endproperty
    a_in_addr: assert property (p_in_addr) else $error("input port address wrong");
    property p_in_store; io_rd && bus_ready |=> mem_wr && addr == ptr_q; endproperty
    a_in_store: assert property (p_in_store) else $error("input byte not stored at pointer");
    property p_imm;
        start && !busy && !ed_prefix && opcode == OPC_OUT_IMM
            |=> io_wr && addr == {$past(reg_a), $past(port_imm)} && data_out == $past(reg_a);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate port write wrong");
    property p_port; io_wr && ed_q |-> addr == {op_q[7] ? b_q - 8'h01 : b_q, c_q}; endproperty
    a_port: assert property (p_port) else $error("register port address wrong");
    property p_output_and_increment_end;
        done && ed_q && op_q == OPC_OUT_INC |-> memory_pointer_pair == ptr_q + 16'h0001 && count_out == b_q - 8'h01;
    endproperty
    a_output_and_increment_end: assert property (p_output_and_increment_end) else $error("pointer or count wrong after output");
    property p_flags; done && ed_q && op_q[7] |-> flags_out[FLAG_N] && flags_out[FLAG_C] == f_q[FLAG_C]; endproperty
    a_flags: assert property (p_flags) else $error("subtract or carry flag wrong");
    property p_zero; done && ed_q && op_q[7] |-> flags_out[FLAG_Z] == (count_out == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_mem_rd; mem_rd |-> addr == ptr_q; endproperty
    a_mem_rd: assert property (p_mem_rd) else $error("memory read address wrong");
    property p_rewind;
        done && ed_q && op_q[7] && op_q[4] |-> program_counter == ((count_out != 8'h00) ? pc_q - PC_REWIND : pc_q);
    endproperty
    a_rewind: assert property (p_rewind) else $error("program counter rewind wrong");
endmodule : iopu_unit_properties

bind iopu_unit iopu_unit_properties u_props (.*);
`default_nettype wire
